// File: hw/dpm_pkg.sv
// Shared constants and carrier types of the display pixel mode control block.
package dpm_pkg;

  // Register addresses as printed, one register per address.
  localparam logic [7:0] DPM_MISC_ADDR   = 8'h43;
  localparam logic [7:0] DPM_GEN_ADDR    = 8'h44;
  localparam logic [7:0] DPM_PIX_ADDR    = 8'h45;
  localparam logic [7:0] DPM_BLANK_ADDR  = 8'h46;
  localparam logic [7:0] DPM_ALPHA_ADDR  = 8'h47;
  localparam logic [7:0] DPM_BORDER_ADDR = 8'h48;
  localparam logic [7:0] DPM_STATUS_ADDR = 8'h71;

  // Writable bit masks; bits outside them read as zero.
  localparam logic [31:0] DPM_MISC_MASK  = 32'h0001_ffff;
  localparam logic [31:0] DPM_GEN_MASK   = 32'h0001_fbff;
  localparam logic [31:0] DPM_PIX_MASK   = 32'h00ff_ffff;
  localparam logic [31:0] DPM_COL_MASK   = 32'h00ff_ffff;
  localparam logic [31:0] DPM_RESET_VAL  = 32'h0000_0000;

  // Miscellaneous control fields.
  localparam int DPM_M_TRAP_LSB = 0;
  localparam int DPM_M_TRAP_SEL = 8;
  localparam int DPM_M_BORDER_A = 9;
  localparam int DPM_M_DIGITIZE = 10;
  localparam int DPM_M_VU_EN    = 11;
  localparam int DPM_M_ALPHA_EN = 12;
  localparam int DPM_M_SW_Y     = 13;
  localparam int DPM_M_GENLOCK  = 14;
  localparam int DPM_M_BYPASS   = 15;
  localparam int DPM_M_SPLIT    = 16;

  // Pixel format control fields.
  localparam int DPM_P_DELAY_LSB = 0;
  localparam int DPM_P_ROUND     = 7;
  localparam int DPM_P_COND      = 8;
  localparam int DPM_P_ILACE     = 9;
  localparam int DPM_P_EXP4      = 10;
  localparam int DPM_P_SAMP_LSB  = 11;
  localparam int DPM_P_PTIME_LSB = 14;
  localparam int DPM_P_BPP_LSB   = 19;
  localparam int DPM_P_HOLD      = 22;
  localparam int DPM_P_PSEUDO    = 23;

  // General control fields.
  localparam int DPM_G_BURST_LSB = 0;
  localparam int DPM_G_CUR_EN    = 5;
  localparam int DPM_G_CUR_H2    = 6;
  localparam int DPM_G_CUR_V2    = 7;
  localparam int DPM_G_CHSEL_LSB = 8;
  localparam int DPM_G_GREN      = 11;
  localparam int DPM_G_VIDEN     = 12;
  localparam int DPM_G_VBLEN_LSB = 13;

  // Status register fields.
  localparam int DPM_S_BUSY   = 0;
  localparam int DPM_S_SWITCH = 1;
  localparam int DPM_S_CODE   = 4;

  // Encodings.
  localparam logic [2:0] DPM_BPP8   = 3'h1;
  localparam logic [2:0] DPM_BPP16  = 3'h2;
  localparam logic [2:0] DPM_BPP32  = 3'h4;
  localparam logic [1:0] DPM_CH_A   = 2'h0;
  localparam logic [1:0] DPM_CH_Y   = 2'h1;
  localparam logic [1:0] DPM_CH_V   = 2'h2;
  localparam logic [2:0] DPM_SAMP_TOP_CODE = 3'h7;
  localparam logic [8:0] DPM_SAMP_TOP      = 9'h100;
  localparam logic [3:0] DPM_CODE_WRITE    = 4'h8;

  // Pixel sample entering the output stage.
  typedef struct packed {
    logic [7:0] top;
    logic [7:0] u;
    logic [7:0] v;
    logic [7:0] y;
  } dpm_pix_in_s;

  // Pixel leaving the output stage.
  typedef struct packed {
    logic [23:0] colour;
    logic [7:0]  alpha;
    logic        vid_switch;
    logic        y_interp2x;
    logic        colour_lookup_table_lsb_force;
    logic        colour_lookup_table_lsb;
    logic        matrix_bypass;
  } dpm_pix_out_s;

  // Decoded operating modes for the pixel path and cursor.
  typedef struct packed {
    logic       round_odd;
    logic       cond_interp;
    logic       interlace;
    logic       expand4x;
    logic       chroma_hold;
    logic [8:0] samples;
    logic [4:0] pix_half_t;
    logic [5:0] bpp;
    logic       fmt16_alpha;
    logic [4:0] burst_div;
    logic       cursor_en;
    logic       cursor_h2;
    logic       cursor_v2;
  } dpm_mode_s;

endpackage

// File: hw/dpm_pixel_out.sv
// Output stage choosing colour, alpha and video/graphics switch per pixel.
module dpm_pixel_out (
  // Clock and reset.
  input  logic                 clk,
  input  logic                 reset_n,
  // Control registers.
  input  logic [31:0]          misc,
  input  logic [31:0]          pixctl,
  input  logic [31:0]          genctl,
  input  logic [31:0]          blank_col,
  input  logic [31:0]          border_col,
  input  logic [31:0]          alpha_val,
  // Pixel and region.
  input  logic                 region_active,
  input  logic                 region_blank,
  input  dpm_pkg::dpm_pix_in_s pix_in,
  output dpm_pkg::dpm_pix_out_s pix_out
);

  typedef struct packed {
    dpm_pkg::dpm_pix_out_s po;
  } dpm_po_state_s;

  dpm_po_state_s s_reg;
  dpm_po_state_s s_next;
  logic          border;
  logic          pseudo;
  logic          sw;
  logic [7:0]    a_sel;

  // Blanking wins over active; anything else is border time.
  always_comb begin
    s_next = s_reg;
    border = !region_active && !region_blank;
    pseudo = (pixctl[dpm_pkg::DPM_P_BPP_LSB +: 3] == dpm_pkg::DPM_BPP32) ||
             (pixctl[dpm_pkg::DPM_P_BPP_LSB +: 3] == dpm_pkg::DPM_BPP16 &&
              pixctl[dpm_pkg::DPM_P_PSEUDO]);
    // R6 R20: switch source.
    if (!misc[dpm_pkg::DPM_M_VU_EN]) begin
      sw = 1'b0;
    end else if (!pixctl[dpm_pkg::DPM_P_COND]) begin
      sw = 1'b1;
    end else if (misc[dpm_pkg::DPM_M_SW_Y]) begin
      sw = pix_in.y[0];
    end else begin
      sw = pix_in.u[0];
    end
    // R18 R2: alpha selection.
    if (region_blank) begin
      a_sel = alpha_val[7:0];
    end else if (border) begin
      a_sel = misc[dpm_pkg::DPM_M_BORDER_A] ? alpha_val[23:16] : alpha_val[7:0];
    end else if (misc[dpm_pkg::DPM_M_TRAP_SEL] && misc[dpm_pkg::DPM_M_ALPHA_EN]) begin
      a_sel = (pix_in.y == misc[dpm_pkg::DPM_M_TRAP_LSB +: 8]) ? alpha_val[15:8]
                                                              : alpha_val[7:0];
    end else begin
      a_sel = pseudo ? pix_in.top : alpha_val[7:0];
    end
    // R15: alpha pins channel select.
    case (genctl[dpm_pkg::DPM_G_CHSEL_LSB +: 2])
      dpm_pkg::DPM_CH_A: s_next.po.alpha = a_sel;
      dpm_pkg::DPM_CH_Y: s_next.po.alpha = pix_in.y;
      dpm_pkg::DPM_CH_V: s_next.po.alpha = pix_in.v;
      default:           s_next.po.alpha = pix_in.u;
    endcase
    // R3 R1: blanking and border colours.
    if (region_blank) begin
      s_next.po.colour = blank_col[23:0];
    end else if (border) begin
      s_next.po.colour = border_col[23:0];
    end else begin
      s_next.po.colour = {pix_in.u, pix_in.v, pix_in.y};
    end
    // R1: matrix bypass flag.
    s_next.po.matrix_bypass = misc[dpm_pkg::DPM_M_BYPASS];
    s_next.po.vid_switch = sw;
    // R16: Y interpolation per pixel kind.
    s_next.po.y_interp2x = sw ? genctl[dpm_pkg::DPM_G_VIDEN] : genctl[dpm_pkg::DPM_G_GREN];
    // R22: colour table halves.
    s_next.po.colour_lookup_table_lsb_force = misc[dpm_pkg::DPM_M_SPLIT];
    s_next.po.colour_lookup_table_lsb = sw;
  end

  // One register stage; every output comes from a flip-flop.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign pix_out = s_reg.po;

  property p_blank_colour;
    @(posedge clk) disable iff (!reset_n)
      region_blank |=> pix_out.colour == $past(blank_col[23:0]);
  endproperty
  a_blank_colour: assert property (p_blank_colour) else $error("blank colour wrong"); // R3

  property p_trap_match;
    @(posedge clk) disable iff (!reset_n)
      region_active && !region_blank && misc[8] && misc[12] && genctl[9:8] == 2'h0 &&
      pix_in.y == misc[7:0] |=> pix_out.alpha == $past(alpha_val[15:8]);
  endproperty
  a_trap_match: assert property (p_trap_match) else $error("trap alpha wrong"); // R18

  property p_graphics_only;
    @(posedge clk) disable iff (!reset_n)
      !misc[11] |=> !pix_out.vid_switch && pix_out.colour_lookup_table_lsb == 1'b0;
  endproperty
  a_graphics_only: assert property (p_graphics_only) else $error("switch not graphics"); // R6

endmodule

// File: hw/dpm_mode_ctrl.sv
// Mode control of the output pixel path with register port and code bus sequencer.
//
// Summary of operation
// R1: Border time sends border colour to matrix; bypass bit feeds YUV straight out.
// R2: Alpha register holds unmatched, matched and border alpha; bit 9 picks border.
// R3: Blanking interval outputs the blanking colour through the matrix.
// R4: Shift clock starts the programmed T-cycles after a transfer begins.
// R5: Bit 7 selects truncate or round-to-odd; bit 10 selects 2X or 4X.
// R6: Bit 8 enables switch from Y/U LSB; VU-enable low means all graphics.
// R7: Bit 9 selects interlaced interpolation reading both V and U per transfer.
// R8: Bits 13:11 pick 0 to 256 chroma samples per V and U.
// R9: Bits 18:14 set pixel duration from a fixed 25-entry code table.
// R10: Bits 21:19 select 8, 16 or 32 bits per pixel.
// R11: Bit 22 holds each interpolated pixel for two pixel times.
// R12: Bit 23 picks 16-bit with alpha, else 6-5-5, in 16-bit mode.
// R13: Bits 4:0 hold negated subcarrier divisor, giving 31 down to 1.
// R14: Cursor enable outputs cursor; bits 6 and 7 double width and height.
// R15: Bits 9:8 route alpha, Y, V or U onto alpha pins.
// R16: Y interpolator doubles graphics with bit 11, video with bit 12.
// R17: Each control code lasts one T-cycle more than bits 16:13.
// R18: Trap select with alpha enable compares Y to trap for matched alpha.
// R19: Digitize bit drives the flag high and marks bitmap codes as writes.
// R20: Bit 13 takes switch from Y LSB, else from interpolator U LSB.
// R21: Genlock lets external line and field resets end line and field.
// R22: Split bit forces colour table address LSB to the switch value.
module dpm_mode_ctrl (
  // Clock and reset.
  input  logic                  clk,
  input  logic                  reset_n,
  // Register port.
  input  logic [7:0]            reg_addr,
  input  logic [31:0]           reg_wdata,
  input  logic                  reg_wr,
  input  logic                  reg_rd,
  output logic [31:0]           reg_rdata,
  // Transfer requests and control code bus.
  input  logic                  xfer_req,
  input  logic [3:0]            xfer_code,
  input  logic                  xfer_bitmap,
  output logic                  xfer_ready,
  output logic [3:0]            control_code_bus,
  output logic                  code_valid,
  output logic                  shift_start,
  // Line and field timing.
  input  logic                  external_line_reset_n,
  input  logic                  external_field_reset_n,
  input  logic                  line_second_half,
  output logic                  line_end,
  output logic                  field_end,
  // Pixel path.
  input  logic                  region_active,
  input  logic                  region_blank,
  input  dpm_pkg::dpm_pix_in_s  pix_in,
  output dpm_pkg::dpm_pix_out_s pix_out,
  // Mode outputs.
  output logic                  digitize_flag_output,
  output dpm_pkg::dpm_mode_s    mode
);

  typedef enum logic [0:0] {
    DPM_ST_IDLE = 1'b0,
    DPM_ST_XFER = 1'b1
  } dpm_xfer_e;

  typedef struct packed {
    dpm_xfer_e          st;
    logic [6:0]         elapsed;
    logic [3:0]         code;
    logic [31:0]        misc;
    logic [31:0]        gen;
    logic [31:0]        pix;
    logic [31:0]        blank;
    logic [31:0]        alpha;
    logic [31:0]        border;
    logic [31:0]        rdata;
    logic               lr_d;
    logic               fr_d;
    logic               line_end;
    logic               field_end;
    dpm_pkg::dpm_mode_s mode;
  } dpm_state_s;

  dpm_state_s s_reg;
  dpm_state_s s_next;
  logic [6:0] delay_m;
  logic [6:0] code_last;
  logic [6:0] xfer_last;
  logic [2:0] samp_code;

  // Pixel duration code to length in half T-cycles; unlisted codes give zero.
  function automatic logic [4:0] pix_time(input logic [4:0] c);
    case (c)
      5'h01:   pix_time = 5'h02;
      5'h02:   pix_time = 5'h03;
      5'h04:   pix_time = 5'h04;
      5'h08:   pix_time = 5'h05;
      5'h10:   pix_time = 5'h06;
      5'h11:   pix_time = 5'h07;
      5'h12:   pix_time = 5'h08;
      5'h14:   pix_time = 5'h09;
      5'h18:   pix_time = 5'h0a;
      5'h19:   pix_time = 5'h0b;
      5'h1a:   pix_time = 5'h0c;
      5'h1c:   pix_time = 5'h0d;
      5'h1d:   pix_time = 5'h0e;
      5'h1e:   pix_time = 5'h0f;
      5'h03:   pix_time = 5'h10;
      5'h05:   pix_time = 5'h11;
      5'h06:   pix_time = 5'h12;
      5'h07:   pix_time = 5'h13;
      5'h09:   pix_time = 5'h14;
      5'h0a:   pix_time = 5'h15;
      5'h0b:   pix_time = 5'h16;
      5'h0c:   pix_time = 5'h17;
      5'h0d:   pix_time = 5'h18;
      5'h0e:   pix_time = 5'h1a;
      5'h0f:   pix_time = 5'h1c;
      default: pix_time = 5'h00;
    endcase
  endfunction

  // Timing figures of the current transfer, taken from live register values.
  always_comb begin
    delay_m = s_reg.pix[dpm_pkg::DPM_P_DELAY_LSB +: 7];
    code_last = {3'h0, s_reg.gen[dpm_pkg::DPM_G_VBLEN_LSB +: 4]};
    xfer_last = (delay_m > code_last) ? delay_m : code_last;
    samp_code = s_reg.pix[dpm_pkg::DPM_P_SAMP_LSB +: 3];
  end

  // Next state: register port, sequencer, genlock and mode decode.
  always_comb begin
    s_next = s_reg;
    // Registered writes; reserved bits are dropped at the door.
    if (reg_wr) begin
      if (reg_addr == dpm_pkg::DPM_MISC_ADDR) begin
        s_next.misc = reg_wdata & dpm_pkg::DPM_MISC_MASK;
      end else if (reg_addr == dpm_pkg::DPM_GEN_ADDR) begin
        s_next.gen = reg_wdata & dpm_pkg::DPM_GEN_MASK;
      end else if (reg_addr == dpm_pkg::DPM_PIX_ADDR) begin
        s_next.pix = reg_wdata & dpm_pkg::DPM_PIX_MASK;
      end else if (reg_addr == dpm_pkg::DPM_BLANK_ADDR) begin
        s_next.blank = reg_wdata & dpm_pkg::DPM_COL_MASK;
      end else if (reg_addr == dpm_pkg::DPM_ALPHA_ADDR) begin
        s_next.alpha = reg_wdata & dpm_pkg::DPM_COL_MASK;
      end else if (reg_addr == dpm_pkg::DPM_BORDER_ADDR) begin
        s_next.border = reg_wdata & dpm_pkg::DPM_COL_MASK;
      end
    end
    // Read data stands only in the cycle after the strobe; unmapped reads zero.
    s_next.rdata = '0;
    if (reg_rd) begin
      if (reg_addr == dpm_pkg::DPM_MISC_ADDR) begin
        s_next.rdata = s_reg.misc;
      end else if (reg_addr == dpm_pkg::DPM_GEN_ADDR) begin
        s_next.rdata = s_reg.gen;
      end else if (reg_addr == dpm_pkg::DPM_PIX_ADDR) begin
        s_next.rdata = s_reg.pix;
      end else if (reg_addr == dpm_pkg::DPM_BLANK_ADDR) begin
        s_next.rdata = s_reg.blank;
      end else if (reg_addr == dpm_pkg::DPM_ALPHA_ADDR) begin
        s_next.rdata = s_reg.alpha;
      end else if (reg_addr == dpm_pkg::DPM_BORDER_ADDR) begin
        s_next.rdata = s_reg.border;
      end else if (reg_addr == dpm_pkg::DPM_STATUS_ADDR) begin
        s_next.rdata[dpm_pkg::DPM_S_BUSY] = (s_reg.st == DPM_ST_XFER);
        s_next.rdata[dpm_pkg::DPM_S_SWITCH] = pix_out.vid_switch;
        s_next.rdata[dpm_pkg::DPM_S_CODE +: 4] = s_reg.code;
      end
    end
    // Transfer sequencer; a request is only taken while idle.
    case (s_reg.st)
      DPM_ST_IDLE: begin
        if (xfer_req) begin
          s_next.st = DPM_ST_XFER;
          s_next.elapsed = '0;
          // R19: bitmap codes become writes.
          s_next.code = (xfer_bitmap && s_reg.misc[dpm_pkg::DPM_M_DIGITIZE]) ?
                        (xfer_code | dpm_pkg::DPM_CODE_WRITE) : xfer_code;
        end
      end
      DPM_ST_XFER: begin
        // R17 R4: stay until both code length and shift delay are spent.
        if (s_reg.elapsed >= xfer_last) begin
          s_next.st = DPM_ST_IDLE;
        end else begin
          s_next.elapsed = s_reg.elapsed + 7'h01;
        end
      end
      default: begin
        s_next.st = DPM_ST_IDLE;
      end
    endcase
    // R21: genlock resets end the line in its second half, and the field.
    s_next.lr_d = external_line_reset_n;
    s_next.fr_d = external_field_reset_n;
    s_next.line_end = s_reg.misc[dpm_pkg::DPM_M_GENLOCK] && s_reg.lr_d &&
                      !external_line_reset_n && line_second_half;
    s_next.field_end = s_reg.misc[dpm_pkg::DPM_M_GENLOCK] && s_reg.fr_d &&
                       !external_field_reset_n;
    // R5 R7 R11: interpolator modes.
    s_next.mode.round_odd = s_reg.pix[dpm_pkg::DPM_P_ROUND];
    s_next.mode.cond_interp = s_reg.pix[dpm_pkg::DPM_P_COND];
    s_next.mode.interlace = s_reg.pix[dpm_pkg::DPM_P_ILACE];
    s_next.mode.expand4x = s_reg.pix[dpm_pkg::DPM_P_EXP4];
    s_next.mode.chroma_hold = s_reg.pix[dpm_pkg::DPM_P_HOLD];
    // R8: samples step by 32, top code is 256.
    s_next.mode.samples = (samp_code == dpm_pkg::DPM_SAMP_TOP_CODE) ?
                          dpm_pkg::DPM_SAMP_TOP : {1'b0, samp_code, 5'h00};
    // R9: pixel duration.
    s_next.mode.pix_half_t = pix_time(s_reg.pix[dpm_pkg::DPM_P_PTIME_LSB +: 5]);
    // R10 R12: depth and 16-bit format.
    case (s_reg.pix[dpm_pkg::DPM_P_BPP_LSB +: 3])
      dpm_pkg::DPM_BPP8:  s_next.mode.bpp = 6'h08;
      dpm_pkg::DPM_BPP16: s_next.mode.bpp = 6'h10;
      dpm_pkg::DPM_BPP32: s_next.mode.bpp = 6'h20;
      default:            s_next.mode.bpp = 6'h00;
    endcase
    s_next.mode.fmt16_alpha = s_reg.pix[dpm_pkg::DPM_P_PSEUDO] &&
      (s_reg.pix[dpm_pkg::DPM_P_BPP_LSB +: 3] == dpm_pkg::DPM_BPP16);
    // R13: divisor is the negated field.
    s_next.mode.burst_div = 5'(5'h00 - s_reg.gen[dpm_pkg::DPM_G_BURST_LSB +: 5]);
    // R14: cursor scaling needs the cursor enabled.
    s_next.mode.cursor_en = s_reg.gen[dpm_pkg::DPM_G_CUR_EN];
    s_next.mode.cursor_h2 = s_reg.gen[dpm_pkg::DPM_G_CUR_EN] &&
                            s_reg.gen[dpm_pkg::DPM_G_CUR_H2];
    s_next.mode.cursor_v2 = s_reg.gen[dpm_pkg::DPM_G_CUR_EN] &&
                            s_reg.gen[dpm_pkg::DPM_G_CUR_V2];
  end

  // Reset idle with all registers cleared; resets read as released.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_reg <= '0;
      s_reg.lr_d <= 1'b1;
      s_reg.fr_d <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // Handshake outputs decode the sequencer state directly.
  assign xfer_ready = (s_reg.st == DPM_ST_IDLE);
  assign code_valid = (s_reg.st == DPM_ST_XFER) && (s_reg.elapsed <= code_last);
  assign shift_start = (s_reg.st == DPM_ST_XFER) && (s_reg.elapsed == delay_m);
  assign control_code_bus = code_valid ? s_reg.code : 4'h0;
  assign reg_rdata = s_reg.rdata;
  assign line_end = s_reg.line_end;
  assign field_end = s_reg.field_end;
  assign mode = s_reg.mode;
  // R19: flag follows the digitize bit.
  assign digitize_flag_output = s_reg.misc[dpm_pkg::DPM_M_DIGITIZE];

  // Per-pixel colour, alpha and switch selection.
  dpm_pixel_out u_pixel_out (
    .clk           (clk),
    .reset_n       (reset_n),
    .misc          (s_reg.misc),
    .pixctl        (s_reg.pix),
    .genctl        (s_reg.gen),
    .blank_col     (s_reg.blank),
    .border_col    (s_reg.border),
    .alpha_val     (s_reg.alpha),
    .region_active (region_active),
    .region_blank  (region_blank),
    .pix_in        (pix_in),
    .pix_out       (pix_out)
  );

  // Helper counters read only by the checks below.
  logic [7:0] cv_run;
  logic [7:0] since;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cv_run <= 8'h00;
      since <= 8'h00;
    end else begin
      cv_run <= code_valid ? cv_run + 8'h01 : 8'h00;
      since <= (s_reg.st == DPM_ST_XFER) ? since + 8'h01 : 8'h00;
    end
  end

  property p_code_len;
    @(posedge clk) disable iff (!reset_n)
      $fell(code_valid) |-> cv_run == {4'h0, s_reg.gen[16:13]} + 8'h01;
  endproperty
  a_code_len: assert property (p_code_len) else $error("code length wrong"); // R17

  property p_shift_delay;
    @(posedge clk) disable iff (!reset_n)
      shift_start |-> since == {1'b0, s_reg.pix[6:0]};
  endproperty
  a_shift_delay: assert property (p_shift_delay) else $error("shift delay wrong"); // R4

  property p_digitize;
    @(posedge clk) disable iff (!reset_n)
      reg_wr && reg_addr == 8'h43 |=> digitize_flag_output == $past(reg_wdata[10]);
  endproperty
  a_digitize: assert property (p_digitize) else $error("digitize flag wrong"); // R19

  property p_alpha_read;
    @(posedge clk) disable iff (!reset_n)
      reg_wr && reg_addr == 8'h47 ##1 reg_rd && reg_addr == 8'h47 && !reg_wr
        |=> reg_rdata == {8'h00, $past(reg_wdata[23:0], 2)};
  endproperty
  a_alpha_read: assert property (p_alpha_read) else $error("alpha readback wrong"); // R2

  property p_no_genlock;
    @(posedge clk) disable iff (!reset_n)
      !s_reg.misc[14] |=> !line_end && !field_end;
  endproperty
  a_no_genlock: assert property (p_no_genlock) else $error("end without genlock"); // R21

  property p_burst;
    @(posedge clk) disable iff (!reset_n)
      1'b1 |=> 5'(mode.burst_div + $past(s_reg.gen[4:0])) == 5'h00;
  endproperty
  a_burst: assert property (p_burst) else $error("burst divisor wrong"); // R13

  property p_refuse;
    @(posedge clk) disable iff (!reset_n)
      xfer_req && !xfer_ready |=> $stable(s_reg.code);
  endproperty
  a_refuse: assert property (p_refuse) else $error("request taken while busy"); // R17

  property p_cursor;
    @(posedge clk) disable iff (!reset_n)
      !s_reg.gen[5] |=> !mode.cursor_h2 && !mode.cursor_v2;
  endproperty
  a_cursor: assert property (p_cursor) else $error("cursor scaled while off"); // R14

  property p_ptime;
    @(posedge clk) disable iff (!reset_n)
      s_reg.pix[18:14] == 5'h0f |=> mode.pix_half_t == 5'h1c;
  endproperty
  a_ptime: assert property (p_ptime) else $error("pixel time wrong"); // R9

  property p_field;
    @(posedge clk) disable iff (!reset_n)
      s_reg.misc[14] && s_reg.fr_d && !external_field_reset_n |=> field_end;
  endproperty
  a_field: assert property (p_field) else $error("field end missing"); // R21

endmodule

// File: bench/dpm_code_rx.sv
// Companion pixel processor model that receives codes on the control code bus.
module dpm_code_rx (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       reset_n,
  // Control code bus.
  input  wire logic [3:0] control_code_bus,
  input  wire logic       code_valid,
  input  wire logic       shift_start,
  // Observed transfer.
  output logic [3:0]      rx_code,
  output logic [7:0]      rx_len,
  output logic [7:0]      rx_shift_k
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] k;
  logic       prev;

  // shift delay measured
  // Timing is taken from the rising edge of valid, so a late code still measures right.
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prev <= 1'b0;
      k <= 8'h00;
      rx_len <= 8'h00;
      rx_code <= 4'h0;
      rx_shift_k <= 8'hff;
    end else begin
      prev <= code_valid;
      k <= (code_valid && !prev) ? 8'h01 : k + 8'h01;
      if (code_valid && !prev) begin
        rx_len <= 8'h01;
        rx_code <= control_code_bus;
      end else if (code_valid) begin
        rx_len <= rx_len + 8'h01;
      end
      if (shift_start) begin
        rx_shift_k <= (code_valid && !prev) ? 8'h00 : k;
      end
    end
  end
endmodule

// File: bench/display_pixel_mode_control_tb.sv
// Self-checking bench of the mode control block with a code bus receiver.
module display_pixel_mode_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, xfer_req = 0, xfer_bitmap = 0;
  logic [7:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0, reg_rdata, d;
  logic [3:0] xfer_code = 0, control_code_bus, rx_code;
  logic xfer_ready, code_valid, shift_start, line_end, field_end, flag;
  logic ext_line_n = 1, ext_field_n = 1, second_half = 0, r_act = 0, r_blank = 0;
  dpm_pkg::dpm_pix_in_s pix_in = 0;
  dpm_pkg::dpm_pix_out_s pix_out;
  dpm_pkg::dpm_mode_s mode;
  logic [7:0] rx_len, rx_shift_k;
  int err_total = 0, samples_checked = 0, cycles = 0, n;
  `define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_total++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end

  dpm_mode_ctrl u_dpm_mode_ctrl (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .xfer_req(xfer_req), .xfer_code(xfer_code), .xfer_bitmap(xfer_bitmap),
    .xfer_ready(xfer_ready), .control_code_bus(control_code_bus), .code_valid(code_valid),
    .shift_start(shift_start), .external_line_reset_n(ext_line_n),
    .external_field_reset_n(ext_field_n), .line_second_half(second_half),
    .line_end(line_end), .field_end(field_end), .region_active(r_act),
    .region_blank(r_blank), .pix_in(pix_in), .pix_out(pix_out),
    .digitize_flag_output(flag), .mode(mode));
  dpm_code_rx u_dpm_code_rx (.clk(clk), .reset_n(reset_n), .control_code_bus(control_code_bus),
    .code_valid(code_valid), .shift_start(shift_start), .rx_code(rx_code), .rx_len(rx_len),
    .rx_shift_k(rx_shift_k));

  // A 4 ns clock and a hang guard.
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      end_sim();
    end
  end

  // One-cycle strobes with a gap cycle between calls.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask
  function automatic logic [8:0] exp_samp(input int c);
    return (c == 7) ? 9'h100 : 9'(c * 32);
  endfunction

  task automatic end_sim();
    $display("counts: checked=%0d mismatches=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    n = $urandom(88);
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    // Miscellaneous register reset value, alpha masked write and read, unmapped place.
    rd(dpm_pkg::DPM_MISC_ADDR, d);
    `CHK(d, 32'h0000_0000)
    d = $urandom();
    @(posedge clk);
    reg_addr <= dpm_pkg::DPM_ALPHA_ADDR;
    reg_wdata <= 32'hff00_0000 | d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 `CHK(reg_rdata, {8'h00, d[23:0]})
    wr(8'h99, 32'hffff_ffff);
    rd(8'h99, d);
    `CHK(d, 32'h0000_0000)
    $display("test registers done");
    // Border, blanking and bypass selection of colour and alpha.
    wr(dpm_pkg::DPM_BORDER_ADDR, 32'h0012_3456);
    wr(dpm_pkg::DPM_BLANK_ADDR, 32'h00ab_cdef);
    wr(dpm_pkg::DPM_ALPHA_ADDR, 32'h0077_5533);
    wr(dpm_pkg::DPM_MISC_ADDR, 32'h0000_8600);
    settle();
    `CHK(pix_out.colour, 24'h12_3456)
    `CHK(pix_out.alpha, 8'h77)
    `CHK(pix_out.matrix_bypass, 1'b1)
    `CHK(flag, 1'b1)
    r_blank <= 1'b1;
    settle();
    `CHK(pix_out.colour, 24'hab_cdef)
    `CHK(pix_out.alpha, 8'h33)
    r_blank <= 1'b0;
    r_act <= 1'b1;
    pix_in <= 32'h1122_335a;
    wr(dpm_pkg::DPM_MISC_ADDR, 32'h0001_1d5a);
    settle();
    `CHK(pix_out.alpha, 8'h55)
    `CHK({pix_out.vid_switch, pix_out.colour_lookup_table_lsb_force, pix_out.colour_lookup_table_lsb}, 3'h7)
    $display("test pixel path done");
    // Depth codes and every sample count setting.
    for (int i = 0; i < 8; i++) begin
      wr(dpm_pkg::DPM_PIX_ADDR, (32'(i) << 11) | (32'h1 << (19 + i % 3)));
      settle();
      `CHK(mode.samples, exp_samp(i))
      `CHK(mode.bpp, 6'(8 << (i % 3)))
    end
    wr(dpm_pkg::DPM_PIX_ADDR, 32'h0093_c080);
    wr(dpm_pkg::DPM_GEN_ADDR, 32'h0000_1061);
    settle();
    `CHK({mode.round_odd, mode.fmt16_alpha, mode.cursor_h2, mode.cursor_v2}, 4'he)
    `CHK({mode.pix_half_t, mode.burst_div, pix_out.y_interp2x}, 11'h73f)
    $display("test modes done");
    // Random code length and shift delay, bitmap codes marked as writes.
    for (int t = 0; t < 6; t++) begin
      n = 2 + $urandom_range(13);
      d = $urandom_range(20);
      wr(dpm_pkg::DPM_GEN_ADDR, 32'(n) << 13);
      wr(dpm_pkg::DPM_PIX_ADDR, d);
      @(posedge clk);
      xfer_req <= 1'b1;
      xfer_code <= 4'(t);
      xfer_bitmap <= t[0];
      @(posedge clk);
      xfer_code <= 4'hf;
      #1 `CHK(xfer_ready, 1'b0)
      @(posedge clk);
      xfer_req <= 1'b0;
      repeat (40) @(posedge clk);
      #1;
      `CHK(rx_len, 8'(n + 1))
      `CHK(rx_shift_k, d[7:0])
      `CHK(rx_code, 4'(t) | (t[0] ? 4'h8 : 4'h0))
    end
    $display("test transfers done");
    // Genlock line end in the second half of a line.
    wr(dpm_pkg::DPM_MISC_ADDR, 32'h0000_4000);
    second_half <= 1'b1;
    @(posedge clk);
    ext_line_n <= 1'b0;
    ext_field_n <= 1'b0;
    n = 0;
    repeat (4) begin
      @(posedge clk);
      #1 n += line_end + 2 * field_end;
    end
    `CHK(n, 3)
    $display("test genlock done");
    end_sim();
  end
endmodule
